// file: piw_window_xlat.sv
//  Contract
// [RULE1] Set CSR mask bit makes matching CSR BAR bit read-only zero.
// [RULE2] Software programs CSR mask only with listed legal window patterns.
// [RULE3] CSR local address bits come from offset where mask bit is zero.
// [RULE4] Set SDRAM mask bit makes matching SDRAM BAR bit read-only zero.
// [RULE5] SDRAM disable bit set makes SDRAM BAR bits 31:28 read-only zero.
// [RULE6] Software sets disable and all mask bits to advertise no window.
// [RULE7] Software programs SDRAM mask only with listed legal window patterns.
// [RULE8] SDRAM local address bits come from offset where mask bit is zero.
// [RULE9] Software writes SDRAM mask and offset before initialize-complete.
// [RULE10] Bits below 18 and masked bits pass through unchanged.
//
// The APB interface to the registers is this design's own decision.
`include "piw_consts.svh"

module piw_window_xlat (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // APB slave
  input  wire piw_pkg::piw_apb_req_t  apbReq,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Inbound address translation
  input  wire piw_pkg::piw_xlat_req_t xlatReq,
  output piw_pkg::piw_xlat_rsp_t      xlatRsp,
  // Writable-bit masks for the two base address registers
  output logic [31:0]                 csrBarWrMask,
  output logic [31:0]                 sdramBarWrMask
);
  import piw_pkg::*;

  localparam int FW = `PIW_FLD_MSB - `PIW_FLD_LSB + 1;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so every answer comes from a flip-flop

  logic          pready_q, pready_d;
  logic [31:0]   prdata_q, prdata_d;
  logic          pslverr_q, pslverr_d;
  logic          wrEn;
  logic          addrHit;
  logic [31:0]   rdMux;

  logic [FW-1:0] csrMask_q, csrMask_d;
  logic [FW-1:0] csrOffs_q, csrOffs_d;
  logic [FW-1:0] sdrMask_q, sdrMask_d;
  logic [FW-1:0] sdrOffs_q, sdrOffs_d;
  logic          sdrDis_q, sdrDis_d;

  // Read decode; reserved bits read as zero
  always_comb begin
    rdMux   = 32'h0000_0000;
    addrHit = 1'b1;
    unique case (apbReq.paddr)
      `PIW_CSR_MASK_OFF:   rdMux[`PIW_FLD_MSB:`PIW_FLD_LSB] = csrMask_q;
      `PIW_CSR_OFFS_OFF:   rdMux[`PIW_FLD_MSB:`PIW_FLD_LSB] = csrOffs_q;
      `PIW_SDRAM_MASK_OFF: begin
        rdMux[`PIW_FLD_MSB:`PIW_FLD_LSB] = sdrMask_q;
        rdMux[`PIW_DIS_BIT]              = sdrDis_q;
      end
      `PIW_SDRAM_OFFS_OFF: rdMux[`PIW_FLD_MSB:`PIW_FLD_LSB] = sdrOffs_q;
      default:             addrHit = 1'b0;
    endcase
  end

  // Access completes on the edge that sees pready high
  assign wrEn = apbReq.psel & apbReq.penable & pready_q & apbReq.pwrite & addrHit;

  // Answer next state; pready is a single-cycle pulse per access
  always_comb begin
    pready_d  = apbReq.psel & apbReq.penable & ~pready_q;
    prdata_d  = pready_d & ~apbReq.pwrite ? rdMux : prdata_q;
    pslverr_d = pready_d & ~addrHit;
  end

  // Register write next state
  always_comb begin
    csrMask_d = csrMask_q;
    csrOffs_d = csrOffs_q;
    sdrMask_d = sdrMask_q;
    sdrOffs_d = sdrOffs_q;
    sdrDis_d  = sdrDis_q;
    if (wrEn) begin
      unique case (apbReq.paddr)
        `PIW_CSR_MASK_OFF:   csrMask_d = apbReq.pwdata[`PIW_FLD_MSB:`PIW_FLD_LSB];
        `PIW_CSR_OFFS_OFF:   csrOffs_d = apbReq.pwdata[`PIW_FLD_MSB:`PIW_FLD_LSB];
        `PIW_SDRAM_MASK_OFF: begin
          sdrMask_d = apbReq.pwdata[`PIW_FLD_MSB:`PIW_FLD_LSB];
          sdrDis_d  = apbReq.pwdata[`PIW_DIS_BIT];
        end
        `PIW_SDRAM_OFFS_OFF: sdrOffs_d = apbReq.pwdata[`PIW_FLD_MSB:`PIW_FLD_LSB];
        default:             sdrDis_d  = sdrDis_q;
      endcase
    end
  end

  // Bus and register state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= `PIW_RDATA_RST;
      pslverr_q <= 1'b0;
      csrMask_q <= `PIW_FLD_RST;
      csrOffs_q <= `PIW_FLD_RST;
      sdrMask_q <= `PIW_FLD_RST;
      sdrOffs_q <= `PIW_FLD_RST;
      sdrDis_q  <= `PIW_DIS_RST;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
      csrMask_q <= csrMask_d;
      csrOffs_q <= csrOffs_d;
      sdrMask_q <= sdrMask_d;
      sdrOffs_q <= sdrOffs_d;
      sdrDis_q  <= sdrDis_d;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Base address register writability, 1 = bit may be written

  logic [31:0] csrBar_q, csrBar_d;
  logic [31:0] sdrBar_q, sdrBar_d;

  // Legal mask patterns are not enforced; an odd pattern just gives an odd window
  always_comb begin
    csrBar_d = 32'hFFFF_FFFF;
    sdrBar_d = 32'hFFFF_FFFF;
    // [RULE1] CSR mask gating
    csrBar_d[`PIW_FLD_MSB:`PIW_FLD_LSB] = ~csrMask_q;
    // [RULE4] SDRAM mask gating
    sdrBar_d[`PIW_FLD_MSB:`PIW_FLD_LSB] = ~sdrMask_q;
    // [RULE5] Disable hides top bits
    sdrBar_d[`PIW_TOP_MSB:`PIW_TOP_LSB] = {4{~sdrDis_q}};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csrBar_q <= 32'hFFFF_FFFF;
      sdrBar_q <= 32'hFFFF_FFFF;
    end else begin
      csrBar_q <= csrBar_d;
      sdrBar_q <= sdrBar_d;
    end
  end

  assign csrBarWrMask   = csrBar_q;
  assign sdramBarWrMask = sdrBar_q;

  ////////////////////////////////////////////////////////////////////////////
  // Inbound translation, one cycle of latency

  piw_xlat_rsp_t xlat_q, xlat_d;
  logic [FW-1:0] selMask;
  logic [FW-1:0] selOffs;

  // Mask bits keep the PCI bit, clear bits take the offset
  always_comb begin
    selMask = (xlatReq.target == PIW_TGT_CSR) ? csrMask_q : sdrMask_q;
    selOffs = (xlatReq.target == PIW_TGT_CSR) ? csrOffs_q : sdrOffs_q;
    xlat_d        = xlatReq;
    // [RULE3] CSR offset substitution
    // [RULE8] SDRAM offset substitution
    // [RULE10] Low and masked bits pass
    xlat_d.addr[`PIW_FLD_MSB:`PIW_FLD_LSB] =
      (xlatReq.addr[`PIW_FLD_MSB:`PIW_FLD_LSB] & selMask) | (selOffs & ~selMask);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xlat_q <= '0;
    end else begin
      xlat_q <= xlat_d;
    end
  end

  assign xlatRsp = xlat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic hitCsrMask;
  logic hitSdrMask;
  assign hitCsrMask = wrEn && apbReq.paddr == `PIW_CSR_MASK_OFF;
  assign hitSdrMask = wrEn && apbReq.paddr == `PIW_SDRAM_MASK_OFF;

  a_csr_bar_gate: assert property ( // [RULE1]
    hitCsrMask |-> ##2 csrBarWrMask[27:18] == ~$past(apbReq.pwdata[27:18], 2))
    else $error("CSR BAR writability does not follow mask write");

  a_sdram_bar_gate: assert property ( // [RULE4]
    hitSdrMask |-> ##2 sdramBarWrMask[27:18] == ~$past(apbReq.pwdata[27:18], 2))
    else $error("SDRAM BAR writability does not follow mask write");

  a_sdram_disable_top: assert property ( // [RULE5]
    hitSdrMask |-> ##2 sdramBarWrMask[31:28] == {4{~$past(apbReq.pwdata[31], 2)}})
    else $error("SDRAM BAR top bits do not follow disable bit");

  a_csr_offset_use: assert property ( // [RULE3]
    xlatReq.valid && xlatReq.target == PIW_TGT_CSR |=> xlatRsp.valid &&
      (xlatRsp.addr[27:18] & ~$past(csrMask_q)) == ($past(csrOffs_q) & ~$past(csrMask_q)))
    else $error("CSR local address ignores offset");

  a_sdram_offset_use: assert property ( // [RULE8]
    xlatReq.valid && xlatReq.target == PIW_TGT_SDRAM |=> xlatRsp.valid &&
      (xlatRsp.addr[27:18] & ~$past(sdrMask_q)) == ($past(sdrOffs_q) & ~$past(sdrMask_q)))
    else $error("SDRAM local address ignores offset");

  a_low_bits_pass: assert property ( // [RULE10]
    xlatReq.valid |=> xlatRsp.addr[17:0] == $past(xlatReq.addr[17:0]) &&
      xlatRsp.addr[31:28] == $past(xlatReq.addr[31:28]))
    else $error("Untranslated address bits altered");

  a_masked_bits_pass: assert property ( // [RULE10]
    xlatReq.valid |=> (xlatRsp.addr[27:18] & $past(selMask)) ==
      ($past(xlatReq.addr[27:18]) & $past(selMask)))
    else $error("Masked address bits not passed through");

  a_apb_one_wait: assert property (
    apbReq.psel && !apbReq.penable ##1 apbReq.psel && apbReq.penable |-> ##1 pready)
    else $error("APB answer not given after one wait state");

  c_no_sdram_window: cover property (hitSdrMask && apbReq.pwdata == 32'h8FFC_0000);
  c_csr_xlat:        cover property (xlatReq.valid && xlatReq.target == PIW_TGT_CSR);
  c_sdram_xlat:      cover property (xlatReq.valid && xlatReq.target == PIW_TGT_SDRAM);
  c_unmapped:        cover property (pready && pslverr);

endmodule

// file: piw_consts.svh
`ifndef PIW_CONSTS_SVH
`define PIW_CONSTS_SVH

// Register byte offsets on the APB
`define PIW_CSR_MASK_OFF    12'h0F8
`define PIW_CSR_OFFS_OFF    12'h0FC
`define PIW_SDRAM_MASK_OFF  12'h100
`define PIW_SDRAM_OFFS_OFF  12'h104

// Window field and disable bit positions
`define PIW_FLD_LSB         18
`define PIW_FLD_MSB         27
`define PIW_TOP_LSB         28
`define PIW_TOP_MSB         31
`define PIW_DIS_BIT         31

// Reset values
`define PIW_FLD_RST         10'h000
`define PIW_DIS_RST         1'b0
`define PIW_RDATA_RST       32'h0000_0000

`endif

// file: piw_pkg.sv
`include "piw_consts.svh"

package piw_pkg;

  // APB request from the bus master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } piw_apb_req_t;

  // Targets of an inbound PCI access
  typedef enum logic {
    PIW_TGT_CSR,
    PIW_TGT_SDRAM
  } piw_target_t;

  // Inbound address to translate
  typedef struct packed {
    logic        valid;
    piw_target_t target;
    logic [31:0] addr;
  } piw_xlat_req_t;

  // Translated local address
  typedef struct packed {
    logic        valid;
    piw_target_t target;
    logic [31:0] addr;
  } piw_xlat_rsp_t;

endpackage

// file: piw_pci_master.sv
module piw_pci_master (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Command from the bench
  input  wire logic                   go,
  input  wire piw_pkg::piw_target_t   tgt,
  input  wire logic [31:0]            addr,
  // Inbound request to the bridge
  output piw_pkg::piw_xlat_req_t      xlatReq
);
  import piw_pkg::*;
  // One request per go; when idle the address inverts on every clock, so it alternates between the last one and its inverse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      xlatReq <= '0;
    else if (go)
      xlatReq <= '{valid: 1'b1, target: tgt, addr: addr};
    else
      xlatReq <= '{valid: 1'b0, target: xlatReq.target, addr: ~xlatReq.addr};
  end
endmodule

// file: piw_window_xlat_bench.sv
module piw_window_xlat_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import piw_pkg::*;
  localparam logic [31:0] FLD = 32'h0FFC_0000;
  logic          ref_clk, rst_n, go, pready, pslverr;
  logic [31:0]   prdata, csrBarWrMask, sdramBarWrMask, pciAddr, rd, rs;
  piw_target_t   tgt;
  piw_apb_req_t  apbReq;
  piw_xlat_req_t xlatReq;
  piw_xlat_rsp_t xlatRsp;
  logic          err;
  int            failCount, nCompared;
  logic [31:0]   mc, ms, oc, os, a;

  piw_window_xlat piw_window_xlat_i (.ref_clk(ref_clk), .rst_n(rst_n), .apbReq(apbReq),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .xlatReq(xlatReq),
    .xlatRsp(xlatRsp), .csrBarWrMask(csrBarWrMask), .sdramBarWrMask(sdramBarWrMask));
  piw_pci_master piw_pci_master_i (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .tgt(tgt),
    .addr(pciAddr), .xlatReq(xlatReq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and seeded xorshift source
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Legal window pattern with k set mask bits from bit 18 upward
  function automatic logic [31:0] pat(input int k);
    return ((32'h1 << k) - 32'h1) << 18;
  endfunction
  function automatic logic [31:0] xl(input logic [31:0] x, m, o);
    return (x & ~FLD) | (x & FLD & m) | (o & FLD & ~m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      $display("unexpected %s exp %h seen %h", name, exp, seen);
      failCount++;
    end
  endtask
  // A wait that runs out counts as a mismatch; every later wait stays bounded too
  task automatic bound(input int n);
    if (n >= 20) begin
      failCount++;
    end
  endtask
  // APB transfer: setup, access, hold until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bound(n);
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
  endtask
  task automatic rchk(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    check("register", rd, e);
    check("slave error", {31'h0, err}, 32'h0);
  endtask
  task automatic xlat(input piw_target_t t, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    go <= 1'b1;
    tgt <= t;
    pciAddr <= a;
    @(posedge ref_clk);
    go <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (xlatRsp.valid !== 1'b1 && n < 20);
    bound(n);
    check("local address", xlatRsp.addr, e);
    check("target", {31'h0, xlatRsp.target}, {31'h0, t});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rs = 32'd17858;
    rst_n     = 1'b0;
    go        = 1'b0;
    tgt       = PIW_TGT_CSR;
    pciAddr   = 32'h0000_0000;
    apbReq    = '0;
    failCount = 0;
    nCompared = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    mc = '0;
    ms = '0;
    oc = '0;
    os = '0;
    for (int i = 0; i < 14; i++) begin
      rchk(12'h0F8, mc & FLD);
      rchk(12'h0FC, oc & FLD);
      rchk(12'h100, ms & 32'h8FFC_0000);
      rchk(12'h104, os & FLD);
      check("csr bar", csrBarWrMask, ~(mc & FLD));
      check("sdram bar", sdramBarWrMask, ~((ms & FLD) | {{4{ms[31]}}, 28'h0}));
      a = rnd();
      xlat(PIW_TGT_CSR, xl(a, mc, oc));
      a = rnd();
      xlat(PIW_TGT_SDRAM, xl(a, ms, os));
      mc = pat(int'(rnd() % 11));
      // no SDRAM window in the last rounds
      ms = (i >= 12) ? 32'h8FFC_0000 : pat(int'(rnd() % 11));
      oc = rnd();
      os = rnd();
      // mask and offset written before any later translation
      apb(1'b1, 12'h0F8, mc);
      apb(1'b1, 12'h0FC, oc);
      apb(1'b1, 12'h100, ms);
      apb(1'b1, 12'h104, os);
      apb(1'b1, 12'h108, rnd());
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h108, 32'h0);
      check("unmapped data", rd, 32'h0);
    end
    // Mid-run reset must clear every window register and reopen the BARs
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk(12'h0F8, 32'h0000_0000);
    rchk(12'h0FC, 32'h0000_0000);
    rchk(12'h100, 32'h0000_0000);
    rchk(12'h104, 32'h0000_0000);
    check("csr bar after reset", csrBarWrMask, 32'hFFFF_FFFF);
    check("sdram bar after reset", sdramBarWrMask, 32'hFFFF_FFFF);
    report_and_stop();
  end
endmodule
